// ---- hw/asp_pkg.sv ----
// Purpose: Constants for the asynchronous serial port
// Assumes: One 250 MHz clock, registers on a plain strobe port
// Notes: Overview of operation follows
// Overview of operation
// - Divisor sets 16x tick, zero stops it
// - Divisor write restarts baud counter
// - Transmit needs tx_enable and module enable
// - Data write starts frame, done flag sticks
// - Idle transmit line rests high
// - Data writes ignored while frame sends
// - Frame: start, 8/9 data, 1/2 stops
// - Data shifted least significant bit first
// - Receive needs rx_enable and module enable
// - Completed frame fills empty buffer, sets full
// - Full buffer: overrun set, new character dropped
// - Overrun, framing, parity flags stay until cleared
// - Falling edge: low after three highs
// - Bits decided by majority of slots 8-10
// - Start bit needs two low votes
// - Falling edges realign slot counter always
// - Multiprocessor mode keeps ninth-bit-one characters
// - Light idle wake needs rx interrupt enable
// - Deep idle low input sets wake flag
// - Instance clock gate, one runs, reset zero
// - Writing one clears flag, zero keeps
// - Nine-bit parity puts parity in ninth bit
// - parity_odd_select one odd, zero even
// - Module disable clears state, re-enable waits
package asp_pkg;
   localparam logic [7:0] A_BD = 8'h00;
   localparam logic [7:0] A_CFG = 8'h04;
   localparam logic [7:0] A_IRQ = 8'h08;
   localparam logic [7:0] A_STS = 8'h0C;
   localparam logic [7:0] A_DAT = 8'h10;
   localparam logic [7:0] A_CLR = 8'h14;
   localparam logic [7:0] A_WAKE = 8'h18;
   localparam logic [7:0] A_GATE = 8'h1C;
   localparam logic [7:0] A_IOS = 8'h40;
   localparam int CFG_EN = 7;
   localparam int CFG_TX_ENABLE = 6;
   localparam int CFG_RX_ENABLE = 5;
   localparam int CFG_MULTI = 4;
   localparam int CFG_STOP2 = 3;
   localparam int CFG_NINE = 2;
   localparam int CFG_PAR = 1;
   localparam int CFG_ODD = 0;
   localparam int IRQ_RXIE = 1;
   localparam int IRQ_FILT = 0;
   localparam int ST_RX_NINTH = 6;
   localparam int ST_TX_NINTH = 5;
   localparam int ST_TXD = 4;
   localparam int ST_RXF = 3;
   localparam int ST_OVR = 2;
   localparam int ST_FE = 1;
   localparam int ST_PE = 0;
   localparam int WK_CLR = 2;
   localparam int WK_FLG = 1;
   localparam int WK_ENABLE = 0;
   localparam int DIV_W = 13;
   localparam int IOS_W = 14;
   localparam logic [4:0] OVS = 5'h10;
   localparam logic [4:0] SL_A = 5'h08;
   localparam logic [4:0] SL_B = 5'h09;
   localparam logic [4:0] SL_C = 5'h0A;
   localparam logic [3:0] TSLOT_LAST = 4'hF;
   localparam logic [7:0] RBUF_RST = 8'hFF;
   localparam int CLK_MHZ = 250;
   localparam int REEN_NS = 500;
   localparam logic [7:0] REEN_CYC = 8'((REEN_NS * CLK_MHZ + 999) / 1000);
   typedef enum logic [0:0] {RX_IDLE = 1'b0, RX_RUN = 1'b1} asp_rx_e;
   typedef enum logic [0:0] {TX_IDLE = 1'b0, TX_SEND = 1'b1} asp_tx_e;
endpackage

// ---- hw/asp_top.sv ----
// Purpose: Asynchronous serial port, transmitter and receiver
// Assumes: Inputs synchronous to mclk_in
// Notes: clk_en_in low freezes every flip-flop
`timescale 1ns/1ns
module asp_top
   import asp_pkg::*;
(
   input wire logic mclk_in,
   input wire logic nrst_in,
   input wire logic clk_en_in,
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   input wire logic rxd_in,
   input wire logic deep_idle_in,
   output logic txd_out,
   output logic wake_req_out
);
   typedef struct packed {
      logic [DIV_W-1:0] div;
      logic [7:0] cfg;
      logic [2:0] irq;
      logic tx_ninth_bit;
      logic txdone;
      logic rxf;
      logic ovr;
      logic fe;
      logic pe;
      logic rx_ninth_bit;
      logic [7:0] rbuf;
      logic warm;
      logic wflg;
      logic gate;
      logic [IOS_W-1:0] ios;
      logic [DIV_W-1:0] bcnt;
      logic [7:0] reen;
      asp_tx_e txs;
      logic [11:0] tsh;
      logic [3:0] tleft;
      logic [3:0] tslot;
      logic txd;
      logic [2:0] filt;
      logic [2:0] hist;
      asp_rx_e rxs;
      logic [4:0] slot;
      logic [3:0] idx;
      logic v8;
      logic v9;
      logic [8:0] rdat;
      logic [31:0] rdata;
      logic wreq;
   } asp_state_s;

   localparam asp_state_s ST_RST = '{
      rbuf: RBUF_RST, txd: 1'b1, txs: TX_IDLE, rxs: RX_IDLE, default: '0};

   function automatic logic maj3(input logic [2:0] v);
      maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
   endfunction

   asp_state_s st_r;
   asp_state_s st_nxt;
   logic run;
   logic tick;
   logic rx_on;
   logic tx_on;
   logic smp;
   logic edge_f;
   logic bitv;
   logic rx_done;
   logic rx_stop;
   logic accept;
   logic rxf_set;
   logic ovr_set;
   logic fe_set;
   logic pe_set;
   logic txd_set;
   logic wk_set;
   logic tx_start;
   logic t9;
   logic [3:0] dbits;
   logic [4:0] clr;

   always_comb
   begin
      st_nxt = st_r;
      tick = 1'b0;
      edge_f = 1'b0;
      bitv = 1'b0;
      rx_done = 1'b0;
      rx_stop = 1'b0;
      rxf_set = 1'b0;
      ovr_set = 1'b0;
      fe_set = 1'b0;
      pe_set = 1'b0;
      txd_set = 1'b0;
      clr = 5'h00;
      run = st_r.gate && !deep_idle_in;
      rx_on = st_r.cfg[CFG_RX_ENABLE] && st_r.cfg[CFG_EN];
      tx_on = st_r.cfg[CFG_TX_ENABLE] && st_r.cfg[CFG_EN];
      dbits = st_r.cfg[CFG_NINE] ? 4'h9 : 4'h8;
      smp = st_r.irq[IRQ_FILT] ? maj3(st_r.filt) : rxd_in;
      accept = !(st_r.cfg[CFG_MULTI] && st_r.cfg[CFG_NINE] && !st_r.rdat[8]);
      t9 = st_r.tx_ninth_bit;
      if (st_r.cfg[CFG_NINE] && st_r.cfg[CFG_PAR])
      begin
         t9 = (^wdata_in[7:0]) ^ st_r.cfg[CFG_ODD];
      end
      tx_start = wr_in && (addr_in == A_DAT) && (st_r.txs == TX_IDLE) && tx_on && run;
      wk_set = deep_idle_in && st_r.warm && rx_on && !rxd_in;
      if (!st_r.cfg[CFG_EN])
      begin
         st_nxt.bcnt = '0;
         st_nxt.txs = TX_IDLE;
         st_nxt.rxs = RX_IDLE;
         st_nxt.hist = 3'h0;
         st_nxt.slot = 5'h00;
         st_nxt.idx = 4'h0;
         st_nxt.tslot = 4'h0;
      end
      else if (run)
      begin
         if (st_r.div != '0)
         begin
            tick = (st_r.bcnt == st_r.div - 13'h0001);
            st_nxt.bcnt = tick ? '0 : st_r.bcnt + 13'h0001;
         end
         st_nxt.filt = {st_r.filt[1:0], rxd_in};
         if (!rx_on)
         begin
            st_nxt.rxs = RX_IDLE;
            st_nxt.hist = 3'h0;
         end
         else if (tick)
         begin
            st_nxt.hist = {st_r.hist[1:0], smp};
            edge_f = (st_r.hist == 3'h7) && !smp;
            case (st_r.rxs)
               RX_IDLE:
               begin
                  if (edge_f)
                  begin
                     st_nxt.rxs = RX_RUN;
                     st_nxt.slot = 5'h02;
                     st_nxt.idx = 4'h0;
                  end
               end
               RX_RUN:
               begin
                  if (edge_f)
                  begin
                     st_nxt.slot = 5'h02;
                     if (st_r.slot > SL_C)
                     begin
                        st_nxt.idx = st_r.idx + 4'h1;
                     end
                  end
                  else
                  begin
                     st_nxt.slot = (st_r.slot == OVS) ? 5'h01 : st_r.slot + 5'h01;
                     if (st_r.slot == OVS)
                     begin
                        st_nxt.idx = st_r.idx + 4'h1;
                     end
                     if (st_r.slot == SL_A)
                     begin
                        st_nxt.v8 = smp;
                     end
                     if (st_r.slot == SL_B)
                     begin
                        st_nxt.v9 = smp;
                     end
                     if (st_r.slot == SL_C)
                     begin
                        bitv = maj3({st_r.v8, st_r.v9, smp});
                        if (st_r.idx == 4'h0)
                        begin
                           if (bitv)
                           begin
                              st_nxt.rxs = RX_IDLE;
                           end
                        end
                        else if (st_r.idx <= dbits)
                        begin
                           st_nxt.rdat[st_r.idx - 4'h1] = bitv;
                        end
                        else
                        begin
                           rx_done = 1'b1;
                           rx_stop = bitv;
                           st_nxt.rxs = RX_IDLE;
                        end
                     end
                  end
               end
               default:
               begin
                  st_nxt.rxs = RX_IDLE;
               end
            endcase
         end
         if (rx_done && accept)
         begin
            fe_set = !rx_stop;
            pe_set = st_r.cfg[CFG_NINE] && st_r.cfg[CFG_PAR] &&
               (st_r.rdat[8] != ((^st_r.rdat[7:0]) ^ st_r.cfg[CFG_ODD]));
            if (st_r.rxf)
            begin
               ovr_set = 1'b1;
            end
            else
            begin
               rxf_set = 1'b1;
               st_nxt.rbuf = st_r.rdat[7:0];
               st_nxt.rx_ninth_bit = st_r.rdat[8];
            end
         end
         if (!tx_on)
         begin
            st_nxt.txs = TX_IDLE;
         end
         else if (tx_start)
         begin
            st_nxt.txs = TX_SEND;
            st_nxt.tslot = 4'h0;
            st_nxt.tleft = 4'h1 + dbits + (st_r.cfg[CFG_STOP2] ? 4'h2 : 4'h1);
            if (st_r.cfg[CFG_NINE])
            begin
               st_nxt.tsh = {2'h3, t9, wdata_in[7:0], 1'b0};
            end
            else
            begin
               st_nxt.tsh = {3'h7, wdata_in[7:0], 1'b0};
            end
         end
         else if ((st_r.txs == TX_SEND) && tick)
         begin
            st_nxt.tslot = st_r.tslot + 4'h1;
            if (st_r.tslot == TSLOT_LAST)
            begin
               st_nxt.tsh = {1'b1, st_r.tsh[11:1]};
               st_nxt.tleft = st_r.tleft - 4'h1;
               if (st_r.tleft == 4'h1)
               begin
                  st_nxt.txs = TX_IDLE;
                  txd_set = 1'b1;
               end
            end
         end
      end
      st_nxt.txd = (st_nxt.txs == TX_SEND) ? st_nxt.tsh[0] : 1'b1;
      if (st_r.reen != 8'h00)
      begin
         st_nxt.reen = st_r.reen - 8'h01;
      end
      if (rd_in)
      begin
         st_nxt.rdata = 32'h0;
         if (addr_in == A_BD)
         begin
            st_nxt.rdata[DIV_W-1:0] = st_r.div;
         end
         else if (addr_in == A_CFG)
         begin
            st_nxt.rdata[7:0] = st_r.cfg;
         end
         else if (addr_in == A_IRQ)
         begin
            st_nxt.rdata[2:0] = st_r.irq;
         end
         else if (addr_in == A_STS)
         begin
            st_nxt.rdata[6:0] = {st_r.rx_ninth_bit, st_r.tx_ninth_bit, st_r.txdone,
               st_r.rxf, st_r.ovr, st_r.fe, st_r.pe};
         end
         else if (addr_in == A_DAT)
         begin
            st_nxt.rdata[7:0] = st_r.rbuf;
         end
         else if (addr_in == A_WAKE)
         begin
            st_nxt.rdata[1:0] = {st_r.wflg, st_r.warm};
         end
         else if (addr_in == A_GATE)
         begin
            st_nxt.rdata[0] = st_r.gate;
         end
         else if (addr_in == A_IOS)
         begin
            st_nxt.rdata[IOS_W-1:0] = st_r.ios;
         end
      end
      if (wr_in)
      begin
         if (addr_in == A_BD)
         begin
            st_nxt.div = wdata_in[DIV_W-1:0];
            st_nxt.bcnt = '0;
         end
         else if (addr_in == A_CFG)
         begin
            st_nxt.cfg = wdata_in[7:0];
            st_nxt.cfg[CFG_EN] = wdata_in[CFG_EN] && (st_r.reen == 8'h00);
            if (st_r.cfg[CFG_EN] && !wdata_in[CFG_EN])
            begin
               st_nxt.reen = REEN_CYC;
            end
         end
         else if (addr_in == A_IRQ)
         begin
            st_nxt.irq = wdata_in[2:0];
         end
         else if (addr_in == A_STS)
         begin
            if (!(st_r.cfg[CFG_NINE] && st_r.cfg[CFG_PAR]))
            begin
               st_nxt.tx_ninth_bit = wdata_in[ST_TX_NINTH];
            end
         end
         else if (addr_in == A_CLR)
         begin
            clr = wdata_in[4:0];
         end
         else if (addr_in == A_WAKE)
         begin
            st_nxt.warm = wdata_in[WK_ENABLE];
            if (wdata_in[WK_CLR])
            begin
               st_nxt.wflg = 1'b0;
            end
         end
         else if (addr_in == A_GATE)
         begin
            st_nxt.gate = wdata_in[0];
         end
         else if (addr_in == A_IOS)
         begin
            st_nxt.ios = wdata_in[IOS_W-1:0];
         end
      end
      // Set wins over clear on every flag
      st_nxt.txdone = (st_r.txdone && !clr[ST_TXD]) || txd_set;
      st_nxt.rxf = (st_r.rxf && !clr[ST_RXF]) || rxf_set;
      st_nxt.ovr = (st_r.ovr && !clr[ST_OVR]) || ovr_set;
      st_nxt.fe = (st_r.fe && !clr[ST_FE]) || fe_set;
      st_nxt.pe = (st_r.pe && !clr[ST_PE]) || pe_set;
      if (!st_r.cfg[CFG_EN])
      begin
         st_nxt.txdone = 1'b0;
         st_nxt.rxf = 1'b0;
         st_nxt.ovr = 1'b0;
         st_nxt.fe = 1'b0;
         st_nxt.pe = 1'b0;
      end
      if (wk_set)
      begin
         st_nxt.wflg = 1'b1;
      end
      st_nxt.wreq = st_nxt.wflg || (st_nxt.rxf && st_nxt.irq[IRQ_RXIE]);
   end

   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         st_r <= ST_RST;
      end
      else if (clk_en_in)
      begin
         st_r <= st_nxt;
      end
   end

   assign rdata_out = st_r.rdata;
   assign txd_out = st_r.txd;
   assign wake_req_out = st_r.wreq;

   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!nrst_in);

   sequence s_start_ok;
      clk_en_in && tx_start;
   endsequence
   sequence s_frame_lo;
      st_r.txs == TX_SEND && !txd_out;
   endsequence

   a_zero_div_tick: assert property (st_r.div == '0 |-> !tick)
      else $error("baud tick with zero divisor");
   a_div_wr_clear: assert property (clk_en_in && wr_in && addr_in == A_BD
      |=> st_r.bcnt == '0)
      else $error("baud counter not cleared");
   a_tx_start_bit: assert property (s_start_ok |=> s_frame_lo)
      else $error("frame did not start low");
   a_idle_line_high: assert property (st_r.txs == TX_IDLE |-> txd_out)
      else $error("idle line not high");
   a_tx_lock_buf: assert property (clk_en_in && st_r.txs == TX_SEND && !tick
      && wr_in && addr_in == A_DAT |=> $stable(st_r.tsh))
      else $error("busy buffer changed");
   a_overrun_keep: assert property (clk_en_in && ovr_set
      |=> st_r.ovr && $stable(st_r.rbuf))
      else $error("overrun lost or buffer replaced");
   a_set_wins: assert property (clk_en_in && rxf_set && clr[ST_RXF]
      |=> st_r.rxf)
      else $error("full flag lost to clear");
   a_edge_align: assert property (clk_en_in && edge_f && rx_on && run
      && st_r.cfg[CFG_EN] |=> st_r.slot == 5'h02)
      else $error("slot not realigned");
   a_bad_start: assert property (clk_en_in && tick && st_r.rxs == RX_RUN
      && st_r.idx == 4'h0 && st_r.slot == SL_C && !edge_f && bitv
      |=> st_r.rxs == RX_IDLE)
      else $error("noisy start accepted");
   a_disable_clear: assert property (clk_en_in && !st_r.cfg[CFG_EN]
      |=> st_r.txs == TX_IDLE && st_r.rxs == RX_IDLE && !st_r.rxf)
      else $error("disable left state");
   a_reen_hold: assert property (st_r.reen != 8'h00 |-> ##1 !$rose(st_r.cfg[CFG_EN]))
      else $error("enabled during holdoff");

endmodule // asp_top

// ---- sim/asp_remote.sv ----
// Purpose: Remote serial station on the far side of the port
// Assumes: One bit lasts BIT_CYC clocks
// Notes: Idle line rests high, as with a pull-up
`timescale 1ns/1ns
module asp_remote #(parameter int BIT_CYC = 16)
(
   input wire logic clk_in,
   input wire logic txd_in,
   input wire logic nine_in,
   output logic rxd_out,
   output logic [9:0] got_out,
   output logic got_stb_out
);
   initial
   begin
      rxd_out = 1'b1;
      got_out = 10'h000;
      got_stb_out = 1'b0;
   end
   // Send one frame, stop level chosen by caller
   task automatic send(input logic [8:0] d, input int nb, input logic stop);
      @(posedge clk_in);
      rxd_out <= 1'b0;
      repeat (BIT_CYC) @(posedge clk_in);
      for (int i = 0; i < nb; i++)
      begin
         rxd_out <= d[i];
         repeat (BIT_CYC) @(posedge clk_in);
      end
      rxd_out <= stop;
      repeat (BIT_CYC) @(posedge clk_in);
      rxd_out <= 1'b1;
      repeat (2 * BIT_CYC) @(posedge clk_in);
   endtask
   // Short low pulse, too brief for a start bit
   task automatic glitch(input int n);
      @(posedge clk_in);
      rxd_out <= 1'b0;
      repeat (n) @(posedge clk_in);
      rxd_out <= 1'b1;
      repeat (2 * BIT_CYC) @(posedge clk_in);
   endtask
   // Capture frames from the port, mid-bit sampling
   always
   begin
      @(negedge txd_in);
      got_out = 10'h000;
      repeat (BIT_CYC / 2) @(posedge clk_in);
      for (int i = 0; i < (nine_in ? 9 : 8); i++)
      begin
         repeat (BIT_CYC) @(posedge clk_in);
         got_out[i] = txd_in;
      end
      repeat (BIT_CYC) @(posedge clk_in);
      got_out[9] = txd_in;
      got_stb_out <= 1'b1;
      @(posedge clk_in);
      got_stb_out <= 1'b0;
   end
endmodule // asp_remote

// ---- sim/asp_top_tb_top.sv ----
// Purpose: Self-checking bench for the serial port
// Assumes: Divisor 1, so one bit is 16 clocks
// Notes: Remote station model plays the far side
`timescale 1ns/1ns
module asp_top_tb_top import asp_pkg::*; ();
   localparam logic [31:0] ALL = 32'hFFFFFFFF;
   logic mclk, nrst, wr, rd, rxd, txd, wake, nine, fstb, rd_seen, cen, deep;
   logic [7:0] addr, d;
   logic [31:0] wdata, rdata, last_rd, m, e, v;
   logic [9:0] fgot;
   logic [63:0] rq[$];
   logic [9:0] fq[$];
   int fail_count, compares;
   asp_top uut (.mclk_in(mclk), .nrst_in(nrst), .clk_en_in(cen), .addr_in(addr),
      .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .rxd_in(rxd),
      .deep_idle_in(deep), .txd_out(txd), .wake_req_out(wake));
   asp_remote #(.BIT_CYC(16)) rem (.clk_in(mclk), .txd_in(txd), .nine_in(nine),
      .rxd_out(rxd), .got_out(fgot), .got_stb_out(fstb));
   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   task automatic chk_rd(input logic [31:0] g, input logic [31:0] x);
      compares++;
      if (g !== x)
      begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   task automatic chk_frm(input logic [9:0] g, input logic [9:0] x);
      compares++;
      if (g !== x)
      begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   task automatic chk_pin(input logic g, input logic x);
      compares++;
      if (g !== x)
      begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] val);
      @(posedge mclk);
      wr <= 1'b1;
      addr <= a;
      wdata <= val;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   // Read, noting expected value and compare mask
   task automatic rreg(input logic [7:0] a, input logic [31:0] x, input logic [31:0] mk);
      @(posedge mclk);
      rd <= 1'b1;
      addr <= a;
      rq.push_back({mk, x});
      @(posedge mclk);
      rd <= 1'b0;
      @(negedge mclk);
      #1;
   endtask
   task automatic wait_sts(input int b);
      for (int i = 0; i < 300; i++)
      begin
         rreg(A_STS, 32'h0, 32'h0);
         if (last_rd[b] === 1'b1)
            return;
      end
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, last_rd, 32'h1 << b);
   endtask
   task automatic end_test(input string s);
      $display("test %s finished", s);
   endtask
   task automatic stop_test();
      $display("compares=%0d mismatches=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge mclk)
      rd_seen <= rd;
   // Read results, oldest note first
   always @(negedge mclk)
   begin
      if (rd_seen === 1'b1)
      begin
         {m, e} = rq.pop_front();
         last_rd = rdata;
         if (m != 32'h0)
            chk_rd(rdata & m, e & m);
      end
   end
   // Frames seen by the remote station
   always @(posedge mclk)
   begin
      if (fstb === 1'b1)
      begin
         if (fq.size() == 0)
            chk_frm(fgot, 10'h000);
         else
            chk_frm(fgot, fq.pop_front());
      end
   end
   initial
   begin
      repeat (20000) @(posedge mclk);
      fail_count++;
      stop_test();
   end
   initial
   begin
      nrst = 1'b0;
      cen = 1'b1;
      deep = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      nine = 1'b0;
      rd_seen = 1'b0;
      last_rd = 32'h0;
      fail_count = 0;
      compares = 0;
      void'($urandom(32'h07D2));
      repeat (3) @(posedge mclk);
      nrst <= 1'b1;
      rreg(A_BD, 32'h0, ALL);
      rreg(A_CFG, 32'h0, ALL);
      rreg(A_STS, 32'h0, ALL);
      rreg(A_DAT, 32'hFF, ALL);
      rreg(A_GATE, 32'h0, ALL);
      wreg(8'h24, ALL);
      rreg(8'h24, 32'h0, ALL);
      v = $urandom & 32'h3FFF;
      wreg(A_IOS, v);
      rreg(A_IOS, v, ALL);
      chk_pin(txd, 1'b1);
      chk_pin(wake, 1'b0);
      end_test("reset");
      wreg(A_GATE, 32'h1);
      rreg(A_GATE, 32'h1, ALL);
      wreg(A_BD, 32'h1);
      wreg(A_CFG, 32'hE0);
      d = 8'($urandom);
      fq.push_back({2'b10, d});
      wreg(A_DAT, {24'h0, d});
      wreg(A_DAT, {24'h0, ~d});
      wait_sts(ST_TXD);
      rreg(A_STS, 32'h10, 32'h1F);
      chk_pin(txd, 1'b1);
      wreg(A_CLR, 32'h10);
      rreg(A_STS, 32'h0, 32'h1F);
      end_test("transmit");
      d = 8'($urandom);
      rem.send({1'b0, d}, 8, 1'b1);
      rreg(A_STS, 32'h08, 32'h1F);
      wreg(A_IRQ, 32'h2);
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      chk_pin(wake, 1'b1);
      rreg(A_DAT, {24'h0, d}, ALL);
      rem.send({1'b0, ~d}, 8, 1'b1);
      rreg(A_STS, 32'h0C, 32'h1F);
      rreg(A_DAT, {24'h0, d}, ALL);
      rem.send({1'b0, ~d}, 8, 1'b0);
      wreg(A_CLR, 32'h0);
      rreg(A_STS, 32'h0E, 32'h1F);
      wreg(A_CLR, 32'h0F);
      rreg(A_STS, 32'h0, 32'h1F);
      chk_pin(wake, 1'b0);
      end_test("receive");
      nine = 1'b1;
      for (int odd = 0; odd < 2; odd++)
      begin
         wreg(A_CFG, 32'(32'hE6 | odd));
         d = 8'($urandom);
         fq.push_back({1'b1, ^d ^ odd[0], d});
         wreg(A_DAT, {24'h0, d});
         wait_sts(ST_TXD);
         wreg(A_CLR, 32'h10);
         rem.send({~(^d ^ odd[0]), d}, 9, 1'b1);
         rreg(A_STS, 32'h09, 32'h1F);
         wreg(A_CLR, 32'h0F);
         rem.send({^d ^ odd[0], d}, 9, 1'b1);
         rreg(A_STS, 32'h08, 32'h1F);
         wreg(A_CLR, 32'h0F);
      end
      end_test("parity");
      wreg(A_CFG, 32'hF4);
      rem.send({1'b0, d}, 9, 1'b1);
      rreg(A_STS, {25'h0, ~(^d), 6'h00}, 32'h4F);
      rem.send({1'b1, ~d}, 9, 1'b1);
      rreg(A_STS, 32'h48, 32'h4F);
      rreg(A_DAT, {24'h0, ~d}, ALL);
      wreg(A_CLR, 32'h0F);
      end_test("multiprocessor");
      wreg(A_CFG, 32'h0);
      wreg(A_DAT, 32'h5A);
      wreg(A_CFG, 32'hE0);
      rreg(A_CFG, 32'h0, 32'h80);
      rreg(A_STS, 32'h0, 32'h1F);
      repeat (130) @(posedge mclk);
      wreg(A_CFG, 32'hE0);
      rreg(A_CFG, 32'hE0, ALL);
      end_test("reenable");
      @(posedge mclk);
      cen <= 1'b0;
      wreg(A_BD, 32'h5);
      cen <= 1'b1;
      rreg(A_BD, 32'h1, ALL);
      end_test("freeze");
      wreg(A_IRQ, 32'h1);
      rem.glitch(4);
      rreg(A_STS, 32'h0, 32'h0F);
      d = 8'($urandom);
      rem.send({1'b0, d}, 8, 1'b1);
      rreg(A_STS, 32'h08, 32'h1F);
      rreg(A_DAT, {24'h0, d}, ALL);
      chk_pin(wake, 1'b0);
      wreg(A_CLR, 32'h0F);
      end_test("filter");
      wreg(A_WAKE, 32'h1);
      @(posedge mclk);
      deep <= 1'b1;
      rem.send({1'b0, d}, 8, 1'b1);
      deep <= 1'b0;
      rreg(A_WAKE, 32'h3, ALL);
      chk_pin(wake, 1'b1);
      rreg(A_STS, 32'h0, 32'h0F);
      wreg(A_WAKE, 32'h5);
      rreg(A_WAKE, 32'h1, ALL);
      chk_pin(wake, 1'b0);
      end_test("wake");
      stop_test();
   end
endmodule // asp_top_tb_top
